// *** sltf_consts.svh ***
// Offsets, field positions, reset values and line characters of the link framing block.
`ifndef SLTF_CONSTS_SVH
`define SLTF_CONSTS_SVH
`define SLTF_OFF_RXST   2'h0
`define SLTF_OFF_RXBUF  2'h1
`define SLTF_OFF_TXCTL  2'h2
`define SLTF_OFF_TXBUF  2'h3
`define SLTF_CTL_BEGIN  0
`define SLTF_CTL_END    1
`define SLTF_CHK_CRC    2'h1
`define SLTF_CHK_EVEN   2'h3
`define SLTF_LOOP_GA    2'h1
`define SLTF_LOOP_AB    2'h2
`define SLTF_FLAG       8'h7e
`define SLTF_ABORT      8'hff
`define SLTF_MARK       16'hffff
`define SLTF_SPACE      16'h0000
`define SLTF_CRC_INIT   16'hffff
`define SLTF_CRC_POLY   16'h8408
`define SLTF_CRC_GOOD   16'hf0b8
`define SLTF_CHAR_LEN   5'h08
`define SLTF_SPACE_LEN  5'h10
`define SLTF_STUFF_RUN  3'h5
`define SLTF_FLAG_RUN   3'h6
`define SLTF_LOOKAHEAD  4'h7
`define SLTF_EMIT_AT    4'he
`endif

// *** sltf_pkg.sv ***
// Types shared by the link framing block.
package sltf_pkg;
  typedef enum logic [2:0] {
    tk_mark, tk_flag, tk_space, tk_data, tk_abort, tk_sync
  } sltf_tx_kind_t;
endpackage : sltf_pkg

// *** sltf_top.sv ***
// Receive status and transmit framing of a synchronous serial link controller.
// Operation
// - Status-available output follows transmit underflow; cleared by master clear or begin.
// - Transmitter processes data only while transmit permit is high.
// - Each serial bit leaves the shifter on the rising transmit clock edge.
// - Loopback routes output to input, inverted clock, ignores input, holds pin high.
// - Bit mode: first byte sets message begin, second byte clears it.
// - Bit mode: last byte or abort sets message end; status read clears.
// - Abort sets flag when loop setting 2, go-ahead when 1; read clears.
// - Byte arriving before previous was read sets overrun; read clears.
// - Unstated boundary end reports count of valid bits in residue field.
// - Bit mode with CRC: failed check sets check result at message end.
// - Character mode with parity: parity error sets check result.
// - Character mode with CRC: check result is one when CRC good, per byte.
// - Message begin takes effect only while transmit permit is high.
// - Bit mode: flags repeat while begin set, data follows once cleared.
// - Character mode begin: sync repeats if idle zero, else buffer data.
// - Bit mode begin and end: sixteen zero bits then a flag.
// - Bit mode end: flags while permitted, mark line once permit drops.
// - Underflow sets error and sends abort/flag or sync/mark by idle select.
// - Master clear empties everything, output high, buffer empty, CRC preset ones.
// - Active rises with first bit; falls half clock after disabled byte.
// - Writes drop buffer empty; loading the shifter raises it.
`timescale 1ns/100ps
`include "sltf_consts.svh"

// ---------------------------------------------------------------------------
// Transmit data FIFO
// ---------------------------------------------------------------------------
module sltf_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_srst,
  // Fill side
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  // Drain side
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  if (D < 2 || (D & (D - 1)) != 0) begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least 2");
  end

  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_in_ready  = cnt_q != (AW + 1)'(D);
  assign o_out_valid = cnt_q != '0;
  assign o_out_data  = mem_q[rp_q];

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_q[wp_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_q + AW'(push);
      rp_q  <= rp_q + AW'(pop);
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule : sltf_fifo

// ---------------------------------------------------------------------------
// Framing top
// ---------------------------------------------------------------------------
module sltf_top #(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and master clear
  input  wire logic       i_mclk,
  input  wire logic       i_srst,
  // Host data port
  input  wire logic       i_dp_strobe,
  input  wire logic       i_dp_write,
  input  wire logic [1:0] i_dp_addr,
  input  wire logic [7:0] i_dp_data,
  output logic [7:0]      o_dp_data,
  output logic            o_dp_data_oe,
  output logic            o_rx_data_avail,
  output logic            o_tx_buffer_empty,
  output logic            o_tx_status_avail,
  // Static configuration
  input  wire logic       i_char_mode,
  input  wire logic [1:0] i_check_mode,
  input  wire logic       i_idle_select,
  input  wire logic [1:0] i_loop_setting,
  input  wire logic [7:0] i_sync_char,
  input  wire logic       i_loopback_select,
  // Serial line
  input  wire logic       i_transmit_shift_clock,
  input  wire logic       i_receive_shift_clock,
  input  wire logic       i_serial_in,
  input  wire logic       i_transmit_permit,
  input  wire logic       i_receive_permit,
  output logic            o_serial_out,
  output logic            o_tx_active
);
  localparam int NS = 5;
  logic [NS-1:0] ext;
  logic [NS-1:0] lv;
  logic tck_q, rck_q, rxc, tx_rise, tx_fall, rx_rise, rx_bit, txen, rxen, bit_oriented_protocol, rv;
  logic so_q, pin_q, st_rd, rb_rd, ctl_wr, tb_wr;

  function automatic logic hit(input logic stb, input logic [1:0] a, input logic [1:0] off);
    hit = stb && (a == off);
  endfunction : hit

  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      rev8[i] = v[7-i];
    end
  endfunction : rev8

  // -------------------------------------------------------------------------
  // Pin synchronisers and edge finding
  // -------------------------------------------------------------------------
  assign ext = {i_receive_permit, i_transmit_permit, i_serial_in,
                i_receive_shift_clock, i_transmit_shift_clock};

  for (genvar g = 0; g < NS; g++) begin : g_sync
    logic s1_q, s2_q, s3_q, lv_q;
    always_ff @(posedge i_mclk) begin
      if (i_srst) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        lv_q <= 1'b0;
      end else begin
        s1_q <= ext[g];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          lv_q <= s3_q;
        end
      end
    end
    assign lv[g] = lv_q;
  end

  assign txen    = lv[3];
  assign rxen    = lv[4];
  assign bit_oriented_protocol     = !i_char_mode;
  assign rxc     = i_loopback_select ? !lv[0] : lv[1];
  assign rx_bit  = i_loopback_select ? so_q : lv[2];
  assign tx_rise = lv[0] && !tck_q;
  assign tx_fall = !lv[0] && tck_q;
  assign rx_rise = rxc && !rck_q;
  assign rv      = rx_rise && rxen;
  assign st_rd   = hit(i_dp_strobe && !i_dp_write, i_dp_addr, `SLTF_OFF_RXST);
  assign rb_rd   = hit(i_dp_strobe && !i_dp_write, i_dp_addr, `SLTF_OFF_RXBUF);
  assign ctl_wr  = hit(i_dp_strobe && i_dp_write, i_dp_addr, `SLTF_OFF_TXCTL);
  assign tb_wr   = hit(i_dp_strobe && i_dp_write, i_dp_addr, `SLTF_OFF_TXBUF);

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tck_q <= 1'b0;
      rck_q <= 1'b0;
    end else begin
      tck_q <= lv[0];
      rck_q <= rxc;
    end
  end

  // -------------------------------------------------------------------------
  // Receive deframer
  // -------------------------------------------------------------------------
  logic [15:0] h_q, crc_q, crc_nx;
  logic [3:0]  n_q;
  logic [2:0]  on_q, rem;
  logic [1:0]  bn_q;
  logic        fr_q, sy_q, ga, flg, abt, stf, psh, eob, fin, ld, crcm, perr, ev_end, ev_ag;
  logic [7:0]  ldv, win, pm;

  // Bit mode holds seven bits back so that a closing flag never reaches the buffer.
  always_comb begin
    ga     = i_loop_setting == `SLTF_LOOP_GA;
    crcm   = i_check_mode == `SLTF_CHK_CRC;
    win    = {rx_bit, h_q[7:1]};
    perr   = i_check_mode[1] && ((^win) == (i_check_mode == `SLTF_CHK_EVEN));
    flg    = bit_oriented_protocol && !rx_bit && on_q == `SLTF_FLAG_RUN;
    abt    = bit_oriented_protocol && rx_bit && on_q == `SLTF_FLAG_RUN;
    stf    = bit_oriented_protocol && !rx_bit && on_q == `SLTF_STUFF_RUN;
    psh    = bit_oriented_protocol && fr_q && !flg && !abt && !stf;
    rem    = 3'(n_q - `SLTF_LOOKAHEAD);
    fin    = bit_oriented_protocol && fr_q && (flg || (abt && ga)) && (bn_q != 2'h0 || rem != 3'h0);
    eob    = bit_oriented_protocol ? (psh && n_q == `SLTF_EMIT_AT) : (sy_q && n_q == 4'h7);
    ld     = rv && (eob || (fin && rem != 3'h0));
    pm     = 8'((16'h1 << rem) - 16'h1);
    ldv    = !bit_oriented_protocol ? win : (fin ? (h_q[14:7] & pm) : rev8(h_q[13:6]));
    ev_end = rv && (fin || (abt && !ga));
    ev_ag  = rv && abt && (ga || i_loop_setting == `SLTF_LOOP_AB);
    crc_nx = {1'b0, crc_q[15:1]} ^ (((bit_oriented_protocol ? h_q[6] : rx_bit) ^ crc_q[0]) ? `SLTF_CRC_POLY : 16'h0);
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst || !rxen) begin
      h_q   <= '0;
      n_q   <= '0;
      on_q  <= '0;
      bn_q  <= '0;
      fr_q  <= 1'b0;
      sy_q  <= 1'b0;
      crc_q <= `SLTF_CRC_INIT;
    end else if (rx_rise) begin
      on_q <= rx_bit ? ((on_q == 3'h7) ? on_q : on_q + 3'h1) : 3'h0;
      if (bit_oriented_protocol) begin
        if (flg) begin
          fr_q  <= 1'b1;
          n_q   <= '0;
          bn_q  <= '0;
          crc_q <= `SLTF_CRC_INIT;
        end else if (abt) begin
          fr_q <= 1'b0;
        end else if (psh) begin
          h_q <= {h_q[14:0], rx_bit};
          n_q <= eob ? `SLTF_LOOKAHEAD : n_q + 4'h1;
          if (n_q >= `SLTF_LOOKAHEAD) begin
            crc_q <= crc_nx;
          end
          if (eob && bn_q != 2'h2) begin
            bn_q <= bn_q + 2'h1;
          end
        end
      end else begin
        h_q <= {8'h00, win};
        if (!sy_q) begin
          sy_q <= win == i_sync_char;
        end else begin
          n_q   <= 4'((n_q + 4'h1) & 4'h7);
          crc_q <= crc_nx;
        end
      end
    end
  end

  // -------------------------------------------------------------------------
  // Receive status and buffer
  // -------------------------------------------------------------------------
  logic [7:0] rdb_q;
  logic [2:0] res_q;
  logic       rda_q, ror_q, rx_msg_begin_q, rx_msg_end_q, rag_q, chk_q;

  // Each set term sits before the read clear so that a same-cycle event survives.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rdb_q  <= '0;
      rda_q  <= 1'b0;
      ror_q  <= 1'b0;
      rx_msg_begin_q <= 1'b0;
      rx_msg_end_q <= 1'b0;
      rag_q  <= 1'b0;
      res_q  <= '0;
    end else begin
      if (ld) begin
        rdb_q <= ldv;
      end
      if (ld && bit_oriented_protocol) begin
        rx_msg_begin_q <= bn_q == 2'h0;
      end
      if (rv && fin) begin
        res_q <= rem;
      end
      rda_q  <= ld || (rda_q && !rb_rd);
      ror_q  <= (ld && rda_q && !rb_rd) || (ror_q && !st_rd && rxen);
      rx_msg_end_q <= ev_end || (rx_msg_end_q && !st_rd && rxen);
      rag_q  <= ev_ag || (rag_q && !st_rd && rxen);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      chk_q <= 1'b0;
    end else if (rv && fin && crcm) begin
      chk_q <= crc_q != `SLTF_CRC_GOOD;
    end else if (rv && !bit_oriented_protocol && eob && crcm) begin
      chk_q <= crc_nx == `SLTF_CRC_GOOD;
    end else if (rv && !bit_oriented_protocol && eob && perr) begin
      chk_q <= 1'b1;
    end else if (st_rd) begin
      chk_q <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // Transmit framer
  // -------------------------------------------------------------------------
  logic [15:0] sh_q, nv;
  logic [4:0]  tn_q, nl;
  logic [2:0]  t1_q;
  logic [7:0]  fd, rd_q;
  logic        bq, eq, err_q, tx_buffer_empty_q, act_q, drop_q, oe_q, unf, stuff, ldt, tb, fpop, fv;
  sltf_pkg::sltf_tx_kind_t tk_q, nk;

  sltf_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .i_mclk      (i_mclk),
    .i_srst      (i_srst),
    .i_in_valid  (tb_wr),
    .o_in_ready  (),
    .i_in_data   (i_dp_data),
    .o_out_valid (fv),
    .i_out_ready (fpop),
    .o_out_data  (fd)
  );

  assign stuff = tk_q == sltf_pkg::tk_data && t1_q == `SLTF_STUFF_RUN;
  assign ldt   = tx_rise && !stuff && tn_q == 5'h0;
  assign fpop  = ldt && nk == sltf_pkg::tk_data;
  assign tb    = stuff ? 1'b0 : ((tn_q == 5'h0) ? nv[0] : sh_q[0]);

  // Next character, chosen only at a character boundary.
  always_comb begin
    nk  = sltf_pkg::tk_mark;
    unf = 1'b0;
    if (!txen) begin
      nk = sltf_pkg::tk_mark;
    end else if (bit_oriented_protocol) begin
      if (tk_q == sltf_pkg::tk_space) begin
        nk = sltf_pkg::tk_flag;
      end else if (bq && eq) begin
        nk = sltf_pkg::tk_space;
      end else if (bq || eq) begin
        nk = sltf_pkg::tk_flag;
      end else if (fv) begin
        nk = sltf_pkg::tk_data;
      end else begin
        unf = tk_q == sltf_pkg::tk_data;
        nk  = (unf && !i_idle_select) ? sltf_pkg::tk_abort : sltf_pkg::tk_flag;
      end
    end else begin
      if (bq && !i_idle_select) begin
        nk = sltf_pkg::tk_sync;
      end else if (fv) begin
        nk = sltf_pkg::tk_data;
      end else begin
        unf = tk_q == sltf_pkg::tk_data && !bq;
        nk  = i_idle_select ? sltf_pkg::tk_mark : sltf_pkg::tk_sync;
      end
    end
    nl = `SLTF_CHAR_LEN;
    nv = `SLTF_MARK;
    unique case (nk)
      sltf_pkg::tk_flag:  nv = {8'h00, `SLTF_FLAG};
      sltf_pkg::tk_space: begin
        nv = `SLTF_SPACE;
        nl = `SLTF_SPACE_LEN;
      end
      sltf_pkg::tk_data:  nv = {8'h00, fd};
      sltf_pkg::tk_abort: nv = {8'h00, `SLTF_ABORT};
      sltf_pkg::tk_sync:  nv = {8'h00, i_sync_char};
      sltf_pkg::tk_mark:  nv = `SLTF_MARK;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      sh_q  <= `SLTF_MARK;
      tn_q  <= '0;
      t1_q  <= '0;
      tk_q  <= sltf_pkg::tk_mark;
      so_q  <= 1'b1;
      pin_q <= 1'b1;
    end else begin
      pin_q <= i_loopback_select || so_q;
      if (tx_rise) begin
        so_q <= tb;
        if (stuff) begin
          t1_q <= '0;
        end else if (tn_q == 5'h0) begin
          sh_q <= {1'b1, nv[15:1]};
          tn_q <= nl - 5'h1;
          tk_q <= nk;
          t1_q <= (nk == sltf_pkg::tk_data && nv[0]) ?
                  ((tk_q == sltf_pkg::tk_data) ? t1_q : 3'h0) + 3'h1 : 3'h0;
        end else begin
          sh_q <= {1'b1, sh_q[15:1]};
          tn_q <= tn_q - 5'h1;
          t1_q <= (tk_q == sltf_pkg::tk_data && sh_q[0]) ? t1_q + 3'h1 : 3'h0;
        end
      end
    end
  end

  // -------------------------------------------------------------------------
  // Transmit control, status and host reads
  // -------------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      bq     <= 1'b0;
      eq     <= 1'b0;
      err_q  <= 1'b0;
      tx_buffer_empty_q <= 1'b1;
    end else begin
      if (ctl_wr) begin
        bq <= i_dp_data[`SLTF_CTL_BEGIN];
        eq <= i_dp_data[`SLTF_CTL_END];
      end
      err_q  <= (ldt && unf) || (err_q && !(ctl_wr && i_dp_data[`SLTF_CTL_BEGIN]));
      tx_buffer_empty_q <= (ctl_wr || tb_wr) ? 1'b0 : (fpop || tx_buffer_empty_q);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      act_q  <= 1'b0;
      drop_q <= 1'b0;
    end else if (ldt && txen && bq) begin
      act_q <= 1'b1;
    end else if (ldt && !txen && act_q) begin
      drop_q <= 1'b1;
    end else if (tx_fall && drop_q) begin
      act_q  <= 1'b0;
      drop_q <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rd_q <= '0;
      oe_q <= 1'b0;
    end else begin
      oe_q <= i_dp_strobe && !i_dp_write;
      if (i_dp_strobe && !i_dp_write) begin
        unique case (i_dp_addr)
          `SLTF_OFF_RXST:  rd_q <= {chk_q, res_q, ror_q, rag_q, rx_msg_end_q, rx_msg_begin_q};
          `SLTF_OFF_RXBUF: rd_q <= rdb_q;
          `SLTF_OFF_TXCTL: rd_q <= {err_q, 5'h00, eq, bq};
          `SLTF_OFF_TXBUF: rd_q <= 8'h00;
        endcase
      end
    end
  end

  assign o_dp_data         = rd_q;
  assign o_dp_data_oe      = oe_q;
  assign o_rx_data_avail   = rda_q;
  assign o_tx_buffer_empty = tx_buffer_empty_q;
  assign o_tx_status_avail = err_q;
  assign o_serial_out      = pin_q;
  assign o_tx_active       = act_q;

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  default clocking cb_m @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  chk_underflow_flag:
    assert property (ldt && unf |=> o_tx_status_avail [*2]) else $error("underflow not flagged");
  chk_mark_when_off:
    assert property (ldt && !txen && !i_loopback_select |=> ##1 o_serial_out)
      else $error("line not at mark without permit");
  chk_shift_edge:
    assert property ($changed(so_q) |-> $past(tx_rise)) else $error("bit left off clock edge");
  chk_loop_pin:
    assert property (i_loopback_select [*2] |-> o_serial_out) else $error("pin not high in loop");
  chk_begin_first:
    assert property (ld && bit_oriented_protocol && bn_q == 2'h0 |=> rx_msg_begin_q) else $error("message begin missing");
  chk_end_read:
    assert property (st_rd && !ev_end |=> !rx_msg_end_q) else $error("message end not cleared");
  chk_overrun_set:
    assert property (ld && rda_q && !rb_rd |=> ror_q && o_rx_data_avail) else $error("overrun lost");
  chk_space_then_flag:
    assert property (ldt && tk_q == sltf_pkg::tk_space && txen |=> tk_q == sltf_pkg::tk_flag)
      else $error("space run not followed by flag");
  chk_empty_drop:
    assert property (ctl_wr || tb_wr |=> !o_tx_buffer_empty) else $error("buffer empty not dropped");
endmodule : sltf_top

// *** sltf_remote.sv ***
// Remote station model: supplies both link clocks and drives the receive line.
`timescale 1ns/100ps

module sltf_remote (
  // Link clocks
  output logic o_tx_clk,
  output logic o_rx_clk,
  // Line data
  output logic o_line
);
  initial begin
    o_tx_clk = 1'b0;
    o_rx_clk = 1'b0;
    o_line   = 1'b1;
  end

  // ---------------------------------------------------------------------------
  // Clocks
  // ---------------------------------------------------------------------------
  // The transmit clock runs free so the block can idle and frame on its own.
  always #32 o_tx_clk = ~o_tx_clk;

  // ---------------------------------------------------------------------------
  // Line driver
  // ---------------------------------------------------------------------------
  // Sends one byte lsb first; the receive clock only runs while bits are sent.
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      o_line = b[i];
      #32 o_rx_clk = 1'b1;
      #32 o_rx_clk = 1'b0;
    end
    // The line is not held after the frame, so it shows the inverse of the last bit.
    o_line = ~b[7];
  endtask : send
endmodule : sltf_remote

// *** tb_top.sv ***
// Self-checking bench of the link framing block.
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end

module tb_top;
  logic       i_mclk;
  logic       i_srst;
  logic       i_dp_strobe;
  logic       i_dp_write;
  logic [1:0] i_dp_addr;
  logic [7:0] i_dp_data;
  logic [7:0] o_dp_data;
  logic       o_dp_data_oe;
  logic       o_rx_data_avail;
  logic       o_tx_buffer_empty;
  logic       o_tx_status_avail;
  logic       i_loopback_select;
  logic       i_char_mode;
  logic [1:0] i_check_mode;
  logic       i_idle_select;
  logic [1:0] i_loop_setting;
  logic [7:0] i_sync_char;
  logic       tx_clk;
  logic       rx_clk;
  logic       line;
  logic       i_transmit_permit;
  logic       i_receive_permit;
  logic       o_serial_out;
  logic       o_tx_active;
  int         n_errors;
  int         n_tests;

  sltf_remote i_remote (.o_tx_clk(tx_clk), .o_rx_clk(rx_clk), .o_line(line));

  sltf_top #(.FIFO_DEPTH(4)) i_dut (
    .i_mclk(i_mclk), .i_srst(i_srst),
    .i_dp_strobe(i_dp_strobe), .i_dp_write(i_dp_write), .i_dp_addr(i_dp_addr),
    .i_dp_data(i_dp_data), .o_dp_data(o_dp_data), .o_dp_data_oe(o_dp_data_oe),
    .o_rx_data_avail(o_rx_data_avail), .o_tx_buffer_empty(o_tx_buffer_empty),
    .o_tx_status_avail(o_tx_status_avail), .i_char_mode(i_char_mode),
    .i_check_mode(i_check_mode), .i_idle_select(i_idle_select),
    .i_loop_setting(i_loop_setting), .i_sync_char(i_sync_char),
    .i_loopback_select(i_loopback_select), .i_transmit_shift_clock(tx_clk),
    .i_receive_shift_clock(rx_clk), .i_serial_in(line),
    .i_transmit_permit(i_transmit_permit), .i_receive_permit(i_receive_permit),
    .o_serial_out(o_serial_out), .o_tx_active(o_tx_active)
  );

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  task automatic tick;
    @(posedge i_mclk);
    #1;
  endtask : tick

  // A wait that ran out ends the run at once.
  task automatic bound(input logic ok);
    n_tests++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("wrong value at %0t: wait ran out %h %h", $time, ok, 1'b1);
      finish_test();
    end
  endtask : bound

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    i_dp_strobe = 1'b1;
    i_dp_write  = 1'b1;
    i_dp_addr   = a;
    i_dp_data   = d;
    tick();
    i_dp_strobe = 1'b0;
    tick();
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    i_dp_strobe = 1'b1;
    i_dp_write  = 1'b0;
    i_dp_addr   = a;
    tick();
    i_dp_strobe = 1'b0;
    `CHK(o_dp_data_oe, 1'b1)
    d = o_dp_data;
    tick();
  endtask : rd

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] s;
    `CHK(o_tx_buffer_empty, 1'b1)
    `CHK(o_serial_out, 1'b1)
    `CHK({o_tx_active, o_tx_status_avail, o_rx_data_avail}, 3'h0)
    rd(2'h0, s);
    `CHK(s, 8'h00)
    rd(2'h2, s);
    `CHK(s, 8'h00)
  endtask : t_reset

  task automatic t_tx;
    logic [7:0] s;
    logic [7:0] sh;
    int         n;
    sh = 8'h00;
    wr(2'h2, 8'h01);
    for (n = 0; n < 64 && sh !== 8'h7e; n++) begin
      @(negedge tx_clk);
      sh = {o_serial_out, sh[7:1]};
    end
    tick();
    bound(sh === 8'h7e);
    `CHK(o_tx_active, 1'b1)
    wr(2'h3, 8'h55);
    `CHK(o_tx_buffer_empty, 1'b0)
    wr(2'h2, 8'h00);
    for (n = 0; n < 4000 && o_tx_status_avail !== 1'b1; n++) tick();
    bound(o_tx_status_avail);
    `CHK(o_tx_buffer_empty, 1'b1)
    rd(2'h2, s);
    `CHK(s[7], 1'b1)
    wr(2'h2, 8'h01);
    for (n = 0; n < 8 && o_tx_status_avail !== 1'b0; n++) tick();
    `CHK(o_tx_status_avail, 1'b0)
    i_transmit_permit = 1'b0;
    for (n = 0; n < 400 && o_tx_active !== 1'b0; n++) tick();
    bound(o_tx_active === 1'b0);
    wr(2'h2, 8'h00);
    i_loopback_select = 1'b1;
    for (n = 0; n < 32; n++) begin
      tick();
      `CHK(o_serial_out, 1'b1)
    end
    i_loopback_select = 1'b0;
  endtask : t_tx

  task automatic t_rx;
    logic [7:0] s;
    int         n;
    i_remote.send(8'h7e);
    i_remote.send(8'h12);
    i_remote.send(8'h34);
    for (n = 0; n < 400 && o_rx_data_avail !== 1'b1; n++) tick();
    bound(o_rx_data_avail);
    rd(2'h0, s);
    `CHK(s[0], 1'b1)
    i_remote.send(8'h56);
    i_remote.send(8'h7e);
    i_remote.send(8'h7e);
    tick();
    rd(2'h0, s);
    `CHK(s[3:0], 4'ha)
    rd(2'h0, s);
    `CHK(s[3:1], 3'h0)
    rd(2'h1, s);
    // An abort ends the message; the block flags the end and the host reads its status then.
    i_remote.send(8'h7e);
    i_remote.send(8'h12);
    i_remote.send(8'hff);
    i_remote.send(8'hff);
    tick();
    rd(2'h0, s);
    `CHK(s[2:1], 2'h3)
    i_remote.send(8'h7e);
    i_remote.send(8'h12);
    i_remote.send(8'hff);
    i_remote.send(8'hff);
    i_receive_permit = 1'b0;
    for (n = 0; n < 8; n++) tick();
    i_receive_permit = 1'b1;
    for (n = 0; n < 8; n++) tick();
    rd(2'h0, s);
    `CHK(s[3:1], 3'h0)
  endtask : t_rx

  task automatic t_ccp;
    logic [7:0] sh;
    int         n;
    sh = 8'h00;
    i_char_mode = 1'b1;
    i_transmit_permit = 1'b1;
    for (n = 0; n < 16; n++) tick();
    wr(2'h2, 8'h01);
    for (n = 0; n < 64 && sh !== i_sync_char; n++) begin
      @(negedge tx_clk);
      sh = {o_serial_out, sh[7:1]};
    end
    tick();
    bound(sh === 8'h16);
    wr(2'h2, 8'h00);
    i_char_mode = 1'b0;
  endtask : t_ccp

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    n_errors          = 0;
    n_tests           = 0;
    i_srst            = 1'b1;
    i_dp_strobe       = 1'b0;
    i_dp_write        = 1'b0;
    i_dp_addr         = 2'h0;
    i_dp_data         = 8'h00;
    i_loopback_select = 1'b0;
    i_char_mode       = 1'b0;
    i_check_mode      = 2'h0;
    i_idle_select     = 1'b0;
    i_loop_setting    = 2'h2;
    i_sync_char       = 8'h16;
    i_transmit_permit = 1'b1;
    i_receive_permit  = 1'b1;
    repeat (3) @(posedge i_mclk);
    #1;
    i_srst = 1'b0;
    tick();
    t_reset();
    t_tx();
    t_rx();
    t_ccp();
    finish_test();
  end

  initial begin
    #400000;
    n_errors++;
    finish_test();
  end
endmodule : tb_top
